// File: bench/pmc_core_pair.sv
`timescale 1ns/1ps
module pmc_core_pair (
  // clock, core state and wait lines
  input  wire logic       mclk_i,
  input  wire logic [1:0] core_sleep_i,
  output logic      [1:0] wait_o
);
  initial wait_o = 2'h0;
  // after dly cycles an active core issues a one-cycle wait
  task automatic issue(input int n, input int dly);
    repeat (dly) @(negedge mclk_i);
    wait_o[n] = !core_sleep_i[n];
    @(negedge mclk_i);
    wait_o[n] = 1'b0;
  endtask
endmodule // pmc_core_pair

// File: bench/pmc_ctrl_asserts.sv
`timescale 1ns/1ps
module pmc_ctrl_asserts
  import pmc_pkg::*;
#(parameter int unsigned NUM_MEM = 4)
(
  // watched ports
  input wire logic               mclk_i,
  input wire logic               arst_n_i,
  input wire logic               clk_en_i,
  input wire logic [1:0]         core_irq_i,
  input wire logic               core1_rst_release_i,
  input wire logic               wake_pin_i,
  input wire logic               rtc_event_i,
  input wire logic               alarm_event_i,
  input wire logic [1:0]         core_clk_en_o,
  input wire logic [1:0]         core_sleep_o,
  input wire logic               periph_pwr_en_o,
  input wire logic [NUM_MEM-1:0] mem_pwr_en_o,
  input wire logic [2:0]         sys_state_o,
  input wire logic               chip_rst_n_o,
  input wire logic               core1_rst_n_o,
  input wire logic [1:0]         clk_src_sel_o
);
  // one domain; any system wake source
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!arst_n_i);
  wire logic wake_w = wake_pin_i | rtc_event_i | alarm_event_i;
  sleep_clk_a: assert property (core_sleep_o[0] |-> !core_clk_en_o[0])
    else $error("sleeping core clocked");
  pd_gate_a: assert property (sys_state_o inside {3'h1, 3'h2, 3'h3}
    |-> !periph_pwr_en_o && core_clk_en_o == 2'h0) else $error("pd not gated");
  ret_mask_a: assert property (sys_state_o == 3'h2
    |-> mem_pwr_en_o == RET_POWER_DOWN) else $error("bad retention");
  wake_only_a: assert property (sys_state_o inside {3'h1, 3'h2, 3'h3}
    && !wake_w |=> $stable(sys_state_o)) else $error("pd left unwoken");
  dpd_boot_a: assert property (sys_state_o == 3'h3 && wake_w && clk_en_i
    |=> sys_state_o == 3'h4 && !chip_rst_n_o && !core1_rst_n_o)
    else $error("no boot reset");
  core1_hold_a: assert property (!core1_rst_n_o && !core1_rst_release_i
    |=> !core1_rst_n_o) else $error("core1 freed");
  irc_sel_a: assert property (clk_src_sel_o == CLK_SRC_IRC)
    else $error("clock source");
  core_wake_a: assert property (sys_state_o == 3'h0 && core_sleep_o[0]
    && core_irq_i[0] && clk_en_i |=> !core_sleep_o[0]) else $error("no wake");
endmodule // pmc_ctrl_asserts
bind pmc_power_mode_controller pmc_ctrl_asserts #(.NUM_MEM(NUM_MEM))
  pmc_ctrl_asserts_inst (.*);

// File: bench/pmc_power_mode_controller_tb_top.sv
`timescale 1ns/1ps
module pmc_power_mode_controller_tb_top;
  import pmc_pkg::*;
  logic mclk_i = 0, arst_n_i = 0, ce = 1, rel = 0, ok = 1, pin = 0, rtc = 0;
  logic alm = 0, periph, chip_n, c1_n, batt, det;
  logic [1:0] irq = 0, ev = 0, pden = 0, lvl = 0, wt, cen, slp, src;
  logic [3:0] mem;
  logic [2:0] st;
  int errors = 0, checks_done = 0, cycles = 0;
  always #2 mclk_i = ~mclk_i;
  pmc_power_mode_controller #(.RST_CYC(2)) pmc_power_mode_controller_inst (
    .mclk_i(mclk_i), .arst_n_i(arst_n_i), .clk_en_i(ce), .wait_instr_i(wt),
    .core_irq_i(irq), .core_event_i(ev), .pd_enable_i(pden), .pd_level_i(lvl),
    .core1_rst_release_i(rel), .wake_pin_i(pin), .rtc_event_i(rtc),
    .alarm_event_i(alm), .main_supply_ok_i(ok), .core_clk_en_o(cen),
    .core_sleep_o(slp), .periph_pwr_en_o(periph), .mem_pwr_en_o(mem),
    .sys_state_o(st), .chip_rst_n_o(chip_n), .core1_rst_n_o(c1_n),
    .clk_src_sel_o(src), .aon_from_battery_o(batt), .aon_wake_det_en_o(det));
  pmc_core_pair pmc_core_pair_inst (.mclk_i(mclk_i), .core_sleep_i(slp),
    .wait_o(wt));
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [3:0] e, input logic [3:0] g);
    checks_done++;
    if (g !== e)
    begin
      errors++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic tally_and_finish;
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // hang guard
  always @(posedge mclk_i)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      errors++;
      tally_and_finish();
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic c1_release;
    ok = 0;
    @(negedge mclk_i);
    chk("batt", 4'h1, {3'h0, batt});
    chk("src", {2'h0, CLK_SRC_IRC}, {2'h0, src});
    chk("det", 4'h1, {3'h0, det});
    chk("c1hold", 4'h0, {3'h0, c1_n});
    rel = 1;
    @(negedge mclk_i);
    rel = 0;
    ok = 1;
    chk("c1free", 4'h1, {3'h0, c1_n});
  endtask
  task automatic sleep_wake;
    ce = 0;
    pmc_core_pair_inst.issue(0, 0);
    ce = 1;
    chk("frozen", 4'h0, {2'h0, slp});
    @(negedge mclk_i);
    pmc_core_pair_inst.issue(0, 0);
    chk("cen", 4'h2, {2'h0, cen});
    chk("periph", 4'h1, {3'h0, periph});
    pmc_core_pair_inst.issue(1, 1);
    chk("both", 4'h7, {1'b0, st == 3'h0, slp});
    irq = 2'h1;
    @(negedge mclk_i);
    irq = 2'h0;
    chk("irq", 4'h2, {2'h0, slp});
    ev = 2'h2;
    @(negedge mclk_i);
    ev = 2'h0;
    chk("event", 4'h0, {2'h0, slp});
  endtask
  task automatic pd_cycle(input logic [1:0] l, input logic [3:0] m, input int s);
    pden = 2'h3;
    lvl = l;
    pmc_core_pair_inst.issue(1, 0);
    chk("lone", 4'h0, {1'b0, st});
    pmc_core_pair_inst.issue(0, 2);
    chk("level", {2'h0, l} + 4'h1, {1'b0, st});
    chk("gate", 4'h0, {1'b0, periph, cen});
    chk("mem", m, mem);
    pden = 2'h0;
    irq = 2'h3;
    @(negedge mclk_i);
    irq = 2'h0;
    chk("ignore", {2'h0, l} + 4'h1, {1'b0, st});
    {alm, rtc, pin} = 3'h1 << s;
    @(negedge mclk_i);
    {alm, rtc, pin} = 3'h0;
    if (l == PD_LVL_DEEP_PD)
    begin
      chk("boot", 4'h4, {1'b0, st});
      chk("rst", 4'h0, {2'h0, chip_n, c1_n});
      for (int i = 0; i < 10 && st !== 3'h0; i++) @(negedge mclk_i);
    end
    chk("run", 4'h0, {1'b0, st});
    chk("runclk", 4'h3, {2'h0, cen});
  endtask
  initial
  begin
    repeat (20) @(negedge mclk_i);
    arst_n_i = 1;
    @(negedge mclk_i);
    c1_release();
    sleep_wake();
    pd_cycle(PD_LVL_DEEP_SLEEP, RET_DEEP_SLEEP, 0);
    pd_cycle(PD_LVL_POWER_DOWN, RET_POWER_DOWN, 1);
    pd_cycle(PD_LVL_DEEP_PD, RET_DEEP_PD, 2);
    c1_release();
    tally_and_finish();
  end
endmodule // pmc_power_mode_controller_tb_top

// File: verilog/pmc_pkg.sv
// How it works
// - five states are kept: per-core active and sleep, plus system deep-sleep, power-down and deep power-down.
// - each core without pd enable moves between active and sleep on its own, whatever its peer does.
// - a sleeping core loses its clock enable while peripheral and memory clocks keep running.
// - every system power-down level gates both cores and all peripherals outside the always-on domain.
// - memory power follows a per-level retention mask for the selected power-down level.
// - only an active core that is enabled for power-down may start a system power-down.
// - with both cores enabled, power-down starts only once both have issued a wait instruction.
// - a sleeping core wakes on an interrupt or an event input for that core, sampled in the same cycle and not latched.
// - sleep wake-up is handled per core, so one core wakes without the other.
// - system power-down is left only on a wake pin, real-time clock or alarm timer event.
// - leaving deep power-down runs a full chip reset and boot instead of resuming.
// - the always-on domain supply selector picks main regulator or battery so it never loses power.
// - per-block resets come from the reset unit; the secondary core stays in reset until software releases it.
// - after power-up or any chip reset the internal rc oscillator is the selected clock source.
package pmc_pkg;
  // system power levels requested by software
  localparam logic [1:0] PD_LVL_DEEP_SLEEP = 2'h0;
  localparam logic [1:0] PD_LVL_POWER_DOWN = 2'h1;
  localparam logic [1:0] PD_LVL_DEEP_PD    = 2'h2;
  // clock source codes
  localparam logic [1:0] CLK_SRC_IRC       = 2'h0;
  // memory retention masks per level, one bit per memory block
  localparam logic [3:0] RET_DEEP_SLEEP    = 4'hF;
  localparam logic [3:0] RET_POWER_DOWN    = 4'h3;
  localparam logic [3:0] RET_DEEP_PD       = 4'h0;
  localparam logic [3:0] RET_ALL           = 4'hF;
  // length of the chip reset pulse after deep power-down wake
  localparam int unsigned BOOT_RST_NS      = 100;
  localparam int unsigned CLK_PERIOD_NS    = 4;
  localparam int unsigned BOOT_RST_CYC     = BOOT_RST_NS / CLK_PERIOD_NS;
  // system state machine
  typedef enum logic [2:0] {
    PMC_RUN   = 3'b000,
    PMC_DSLP  = 3'b001,
    PMC_PD    = 3'b010,
    PMC_DPD   = 3'b011,
    PMC_RESET = 3'b100
  } pmc_state_t;
endpackage

// File: verilog/pmc_power_mode_controller.sv
`timescale 1ns/1ps
module pmc_power_mode_controller
  import pmc_pkg::*;
#(
  parameter int unsigned NUM_MEM  = 4,
  parameter int unsigned RST_CYC  = pmc_pkg::BOOT_RST_CYC
)(
  // clock, reset, enable
  input  wire logic                 mclk_i,
  input  wire logic                 arst_n_i,
  input  wire logic                 clk_en_i,
  // per-core wait instructions, wake requests and power-down enables
  input  wire logic [1:0]           wait_instr_i,
  input  wire logic [1:0]           core_irq_i,
  input  wire logic [1:0]           core_event_i,
  input  wire logic [1:0]           pd_enable_i,
  // system power-down request
  input  wire logic [1:0]           pd_level_i,
  // secondary core reset release from software
  input  wire logic                 core1_rst_release_i,
  // always-on wake sources and main supply status
  input  wire logic                 wake_pin_i,
  input  wire logic                 rtc_event_i,
  input  wire logic                 alarm_event_i,
  input  wire logic                 main_supply_ok_i,
  // core and domain controls
  output logic [1:0]                core_clk_en_o,
  output logic [1:0]                core_sleep_o,
  output logic                      periph_pwr_en_o,
  output logic [NUM_MEM-1:0]        mem_pwr_en_o,
  output logic [2:0]                sys_state_o,
  output logic                      chip_rst_n_o,
  output logic                      core1_rst_n_o,
  output logic [1:0]                clk_src_sel_o,
  output logic                      aon_from_battery_o,
  output logic                      aon_wake_det_en_o
);
  import pmc_pkg::*;

  // refuse sizes the retention masks and the 8-bit reset counter cannot serve
  if (NUM_MEM != 4 || RST_CYC < 1 || RST_CYC > 256)
  begin : g_param_check
    $error("pmc: NUM_MEM must be 4 and RST_CYC within 1 to 256");
  end

  //////////////////////////////////////////////////////////////////////////
  pmc_state_t       state_q, state_d;
  logic [1:0]       sleep_q, sleep_d;
  logic [1:0]       wait_seen_q, wait_seen_d;
  logic [7:0]       rst_cnt_q;
  logic             core1_rel_q;

  // wake decodes
  wire              sys_wake   = wake_pin_i | rtc_event_i | alarm_event_i;
  wire [1:0]        core_wake  = core_irq_i | core_event_i;
  wire [1:0]        active     = ~sleep_q;
  // cores eligible to request system power-down
  wire [1:0]        pd_req     = wait_instr_i & active & pd_enable_i;
  wire [1:0]        seen_now   = wait_seen_q | pd_req;
  wire              both_en    = &pd_enable_i;
  // agreement: every enabled core has issued its wait instruction
  wire              pd_agree   = (|pd_req) &&
                                 ((seen_now & pd_enable_i) == pd_enable_i);
  wire              in_run     = (state_q == PMC_RUN);
  wire              rst_done   = (rst_cnt_q == 8'h00);

  //////////////////////////////////////////////////////////////////////////
  // per-core sleep; a core without pd enable sleeps on its own
  genvar g;
  generate
    for (g = 0; g < 2; g++)
    begin : g_core
      always_comb
      begin
        sleep_d[g] = sleep_q[g];
        if (!in_run)
          sleep_d[g] = 1'b0;
        else if (sleep_q[g] && core_wake[g])
          sleep_d[g] = 1'b0;
        else if (wait_instr_i[g] && !pd_enable_i[g])
          sleep_d[g] = 1'b1;
      end
      assign core_clk_en_o[g] = in_run && !sleep_q[g];
    end
  endgenerate

  // wait collection for the two-core agreement
  always_comb
  begin
    wait_seen_d = wait_seen_q;
    if (!in_run || pd_agree)
      wait_seen_d = 2'b00;
    else if (both_en)
      wait_seen_d = seen_now;
  end

  //////////////////////////////////////////////////////////////////////////
  // system state transitions
  always_comb
  begin
    state_d = state_q;
    unique case (state_q)
      PMC_RUN:
        if (pd_agree)
        begin
          unique case (pd_level_i)
            PD_LVL_DEEP_SLEEP: state_d = PMC_DSLP;
            PD_LVL_POWER_DOWN: state_d = PMC_PD;
            default:           state_d = PMC_DPD;
          endcase
        end
      PMC_DSLP, PMC_PD:
        if (sys_wake)
          state_d = PMC_RUN;
      PMC_DPD:
        if (sys_wake)
          state_d = PMC_RESET;
      PMC_RESET:
        if (rst_done)
          state_d = PMC_RUN;
      default:
        state_d = PMC_RESET;
    endcase
  end

  //////////////////////////////////////////////////////////////////////////
  // state registers
  always_ff @(posedge mclk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      state_q     <= PMC_RUN;
      sleep_q     <= 2'b00;
      wait_seen_q <= 2'b00;
    end
    else if (clk_en_i)
    begin
      state_q     <= state_d;
      sleep_q     <= sleep_d;
      wait_seen_q <= wait_seen_d;
    end
  end

  // chip reset pulse counter after deep power-down wake
  always_ff @(posedge mclk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      rst_cnt_q <= 8'h00;
    else if (clk_en_i)
    begin
      if (state_q == PMC_DPD && sys_wake)
        rst_cnt_q <= 8'(RST_CYC - 1);
      else if (!rst_done)
        rst_cnt_q <= rst_cnt_q - 8'h01;
    end
  end

  // secondary core reset release; cleared again by chip reset
  always_ff @(posedge mclk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      core1_rel_q <= 1'b0;
    else if (clk_en_i)
    begin
      if (state_q == PMC_RESET)
        core1_rel_q <= 1'b0;
      else if (core1_rst_release_i)
        core1_rel_q <= 1'b1;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // outputs
  wire [3:0] ret_mask = (state_q == PMC_DSLP) ? RET_DEEP_SLEEP :
                        (state_q == PMC_PD)   ? RET_POWER_DOWN :
                        (state_q == PMC_DPD)  ? RET_DEEP_PD    :
                                                RET_ALL;

  assign core_sleep_o       = sleep_q;
  assign sys_state_o        = state_q;
  assign periph_pwr_en_o    = in_run;
  assign mem_pwr_en_o       = ret_mask;
  assign chip_rst_n_o       = (state_q != PMC_RESET);
  assign core1_rst_n_o      = core1_rel_q && chip_rst_n_o;
  assign clk_src_sel_o      = CLK_SRC_IRC;
  assign aon_from_battery_o = !main_supply_ok_i;
  assign aon_wake_det_en_o  = 1'b1;
endmodule // pmc_power_mode_controller
